// [design/asfs_pkg.sv]
// Purpose: Constants for the ADC sample queue status block
// Assumes: Byte-wide I/O register port, one system clock
// Notes:   Offsets are I/O offsets within the board window
package asfs_pkg;
    localparam logic [3:0]  ASFS_OFF_STATUS_HIGH = 4'hA;
    localparam logic [3:0]  ASFS_OFF_STATUS_LOW  = 4'hF;
    localparam logic [3:0]  ASFS_OFF_DATA        = 4'h0;
    localparam logic [3:0]  ASFS_OFF_CHANNEL     = 4'h2;
    localparam logic [3:0]  ASFS_OFF_ADC_CTRL    = 4'h9;
    localparam logic [3:0]  ASFS_OFF_IRQ_SEL     = 4'h8;
    localparam logic [3:0]  ASFS_OFF_IRQ_CLEAR   = 4'h1;
    localparam int          ASFS_IRQ_ENABLE_BIT  = 3;
    localparam int          ASFS_BLKSEL_LSB      = 0;
    localparam int          ASFS_BIT_IRQ         = 7;
    localparam int          ASFS_BIT_FRAG        = 6;
    localparam int          ASFS_BIT_FULL        = 5;
    localparam int          ASFS_BIT_EMPTY       = 4;
    localparam int          ASFS_LEGACY_SAMPLES  = 512;
    localparam int          ASFS_BLOCK_SAMPLES   = 256;
    localparam logic [1:0]  ASFS_BLKSEL_RESET    = 2'h0;
    localparam logic        ASFS_IRQ_EN_RESET    = 1'b0;
    localparam logic [11:0] ASFS_BLOCKS_RESET    = 12'h000;
endpackage

// [design/asfs_top.sv]
// Purpose: Status flags, block count and fragment staging for the sample queue
// Assumes: Host strobes are already synchronous to i_clk_sys
// Notes:   Storage is a flip-flop queue plus a small fragment buffer
`timescale 1ns/1ns
module asfs_top
    import asfs_pkg::*;
#(
    parameter int DEPTH_LOG2 = 12,
    parameter int FRAG_LOG2  = 4
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_superset_option_jumper,
    input  wire logic        i_sample_valid,
    input  wire logic [15:0] i_sample_data,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic [3:0]  i_io_addr,
    input  wire logic [7:0]  i_io_wdata,
    input  wire logic        i_data_rd,
    output logic      [7:0]  o_io_rdata,
    output logic      [15:0] o_data,
    output logic             o_data_valid,
    output logic             o_io_wait,
    output logic             o_irq
);
    localparam int DEPTH = 1 << DEPTH_LOG2;
    localparam int FRAG  = 1 << FRAG_LOG2;

    // ------------------------------------------------------------
    // Register writes and configuration
    // ------------------------------------------------------------
    wire wr_channel = i_io_wr && (i_io_addr == ASFS_OFF_CHANNEL);
    wire wr_clear   = i_io_wr && (i_io_addr == ASFS_OFF_IRQ_CLEAR);
    wire wr_ctrl    = i_io_wr && (i_io_addr == ASFS_OFF_ADC_CTRL);
    wire wr_blksel  = i_io_wr && (i_io_addr == ASFS_OFF_IRQ_SEL);

    logic       irq_en_reg;
    logic [1:0] blksel_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_en_reg <= ASFS_IRQ_EN_RESET;
            blksel_reg <= ASFS_BLKSEL_RESET;
        end else begin
            if (wr_ctrl)
                irq_en_reg <= i_io_wdata[ASFS_IRQ_ENABLE_BIT];
            if (wr_blksel)
                blksel_reg <= i_io_wdata[ASFS_BLKSEL_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Main queue
    // ------------------------------------------------------------
    logic [15:0]         mem [DEPTH];
    logic [DEPTH_LOG2-1:0] wptr_reg;
    logic [DEPTH_LOG2-1:0] rptr_reg;
    logic [DEPTH_LOG2:0]   qcount_reg;

    // Fragment buffer ahead of the host port
    logic [15:0]          frag [FRAG];
    logic [FRAG_LOG2-1:0] fw_reg;
    logic [FRAG_LOG2-1:0] fr_reg;
    logic [FRAG_LOG2:0]   fcount_reg;

    wire q_full    = (qcount_reg == (DEPTH_LOG2+1)'(DEPTH));
    wire q_empty   = (qcount_reg == '0);
    wire f_full    = (fcount_reg == (FRAG_LOG2+1)'(FRAG));
    wire f_empty   = (fcount_reg == '0);
    // Overflowing samples are dropped; the sticky flag tells software
    wire q_push    = i_sample_valid && !q_full && !wr_channel;
    wire overflow  = i_sample_valid && q_full && !wr_channel;
    wire host_pop  = i_data_rd && !f_empty && !wr_channel;
    wire q_to_frag = !q_empty && (!f_full || host_pop) && !wr_channel;
    wire f_push    = q_to_frag;

    always_ff @(posedge i_clk_sys) begin
        if (q_push)
            mem[wptr_reg] <= i_sample_data;
        if (f_push)
            frag[fw_reg] <= mem[rptr_reg];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || wr_channel) begin
            wptr_reg   <= '0;
            rptr_reg   <= '0;
            qcount_reg <= '0;
            fw_reg     <= '0;
            fr_reg     <= '0;
            fcount_reg <= '0;
        end else begin
            if (q_push)
                wptr_reg <= wptr_reg + 1'b1;
            if (q_to_frag)
                rptr_reg <= rptr_reg + 1'b1;
            qcount_reg <= qcount_reg + (DEPTH_LOG2+1)'(q_push) - (DEPTH_LOG2+1)'(q_to_frag);
            if (f_push)
                fw_reg <= fw_reg + 1'b1;
            if (host_pop)
                fr_reg <= fr_reg + 1'b1;
            fcount_reg <= fcount_reg + (FRAG_LOG2+1)'(f_push) - (FRAG_LOG2+1)'(host_pop);
        end
    end

    // ------------------------------------------------------------
    // Flags and counts
    // ------------------------------------------------------------
    // Samples held anywhere: main queue plus fragment buffer
    wire [DEPTH_LOG2+1:0] total = (DEPTH_LOG2+2)'(qcount_reg) + (DEPTH_LOG2+2)'(fcount_reg);
    wire [DEPTH_LOG2+1:0] total_next = total + (DEPTH_LOG2+2)'(q_push) - (DEPTH_LOG2+2)'(host_pop);
    // Counts above 12 bits saturate rather than wrap
    wire [DEPTH_LOG2+1:0] blocks_wide = total_next >> 8;
    wire [11:0] blocks_next = (blocks_wide > (DEPTH_LOG2+2)'(12'hFFF)) ? 12'hFFF : blocks_wide[11:0];
    wire [DEPTH_LOG2+1:0] irq_limit = (DEPTH_LOG2+2)'(ASFS_LEGACY_SAMPLES) <<
                                      blksel_reg;
    wire irq_hit = (total_next >= irq_limit);

    // Set only on crossing the threshold, so a clear sticks while still above it
    logic        hit_reg;
    wire         irq_set = irq_hit && !hit_reg;

    logic        irq_flag_reg;
    logic        full_reg;
    logic        empty_reg;
    logic        frag_reg;
    logic [11:0] blocks_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || wr_channel) begin
            irq_flag_reg <= 1'b0;
            hit_reg      <= 1'b0;
            full_reg     <= 1'b0;
            empty_reg    <= 1'b1;
            frag_reg     <= 1'b0;
            blocks_reg   <= ASFS_BLOCKS_RESET;
        end else begin
            // Set wins over a simultaneous clear
            hit_reg      <= irq_hit;
            irq_flag_reg <= irq_set || (irq_flag_reg && !wr_clear);
            full_reg     <= full_reg || overflow || (total_next >= (DEPTH_LOG2+2)'(DEPTH));
            empty_reg    <= (total_next == '0);
            frag_reg     <= ((fcount_reg + (FRAG_LOG2+1)'(f_push) - (FRAG_LOG2+1)'(host_pop)) != '0);
            blocks_reg   <= blocks_next;
        end
    end

    // ------------------------------------------------------------
    // Host read port
    // ------------------------------------------------------------
    wire [7:0] status_high = {irq_flag_reg, frag_reg, full_reg, empty_reg, blocks_reg[11:8]};
    wire [7:0] status_low  = blocks_reg[7:0];
    wire sel_high = i_io_rd && (i_io_addr == ASFS_OFF_STATUS_HIGH) && i_superset_option_jumper;
    wire sel_low  = i_io_rd && (i_io_addr == ASFS_OFF_STATUS_LOW) && i_superset_option_jumper;
    wire [7:0] rdata_next = sel_high ? status_high : (sel_low ? status_low : 8'h00);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_io_rdata   <= 8'h00;
            o_data       <= 16'h0000;
            o_data_valid <= 1'b0;
            o_io_wait    <= 1'b0;
            o_irq        <= 1'b0;
        end else begin
            o_io_rdata   <= rdata_next;
            o_data       <= host_pop ? frag[fr_reg] : o_data;
            o_data_valid <= host_pop;
            // Stall only when the read outruns the staged data
            o_io_wait    <= i_data_rd && f_empty && !q_empty;
            o_irq        <= irq_flag_reg && irq_en_reg && i_superset_option_jumper;
        end
    end
endmodule

// [tb/asfs_host.sv]
// Purpose: Host CPU model on the byte I/O port
// Assumes: One-clock strobes launched at the falling edge
// Notes:   Answer taken one clock after the strobe
`timescale 1ns/1ns
module asfs_host (
    input  wire logic        i_clk_sys,
    input  wire logic [7:0]  i_io_rdata,
    input  wire logic [15:0] i_data,
    input  wire logic        i_data_valid,
    output logic             o_io_wr = 1'h0,
    output logic             o_io_rd = 1'h0,
    output logic      [3:0]  o_io_addr = 4'h0,
    output logic      [7:0]  o_io_wdata = 8'h00,
    output logic             o_data_rd = 1'h0
);
    // Strobes are {pop, read, write}; a spare clock keeps transfers apart
    task automatic xfer(input logic [2:0] s, input logic [3:0] a, input logic [7:0] d, output logic [24:0] r);
        {o_data_rd, o_io_rd, o_io_wr} = s;
        o_io_addr = a;
        o_io_wdata = d;
        @(negedge i_clk_sys);
        {o_data_rd, o_io_rd, o_io_wr} = 3'h0;
        o_io_wdata = ~d;
        r = {i_data_valid, i_data, i_io_rdata};
        @(negedge i_clk_sys);
    endtask
endmodule

// [tb/asfs_props.sv]
// Purpose: Port assertions for the sample queue status block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound onto asfs_top below the module
`timescale 1ns/1ns
module asfs_props
    import asfs_pkg::*;
#(parameter int DEPTH_LOG2 = 12, parameter int FRAG_LOG2 = 4) (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic       i_superset_option_jumper,
    input wire logic       i_io_wr,
    input wire logic       i_io_rd,
    input wire logic [3:0] i_io_addr,
    input wire logic       i_data_rd,
    input wire logic [7:0] o_io_rdata,
    input wire logic       o_data_valid,
    input wire logic       o_io_wait,
    input wire logic       o_irq
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire st = i_io_addr == ASFS_OFF_STATUS_HIGH || i_io_addr == ASFS_OFF_STATUS_LOW;
    a_irq_jumper: assert property (o_irq |-> $past(i_superset_option_jumper)) else $error("irq without jumper");
    a_status_gated: assert property (i_io_rd && !i_superset_option_jumper |=> o_io_rdata == 8'h00) else $error("gated");
    a_unmapped_zero: assert property (i_io_rd && !st |=> o_io_rdata == 8'h00) else $error("unmapped read");
    a_rdata_idle: assert property (!i_io_rd |=> o_io_rdata == 8'h00) else $error("read data without read");
    a_reset_quiet: assert property ($fell(i_rst) |-> !o_irq && !o_data_valid && !o_io_wait) else $error("reset");
    a_valid_after_pop: assert property (o_data_valid |-> $past(i_data_rd)) else $error("stray data valid");
    a_wait_after_pop: assert property (o_io_wait |-> $past(i_data_rd) && !o_data_valid) else $error("stray wait");
    a_chan_clears: assert property (i_io_wr && i_io_addr == ASFS_OFF_CHANNEL |=> ##1 !o_irq) else $error("irq kept");
    c_irq: cover property ($rose(o_irq));
    c_pop: cover property (o_data_valid);
    c_status: cover property (i_io_rd && st && i_superset_option_jumper);
endmodule
bind asfs_top asfs_props #(.DEPTH_LOG2(DEPTH_LOG2), .FRAG_LOG2(FRAG_LOG2)) i_asfs_props (.i_clk_sys, .i_rst,
    .i_superset_option_jumper, .i_io_wr, .i_io_rd, .i_io_addr, .i_data_rd, .o_io_rdata, .o_data_valid, .o_io_wait, .o_irq);

// [tb/asfs_top_test.sv]
// Purpose: Self-checking bench for asfs_top
// Assumes: Queue depth cut to 1024 samples
// Notes:   Rows share one queue history
`timescale 1ns/1ns
module asfs_top_test;
    import asfs_pkg::*;
    typedef struct packed {logic [3:0] wa; logic [7:0] wd; logic j; logic [10:0] n, m; logic [7:0] hi, lo; logic irq;} asfs_row_t;
    asfs_row_t rows [9] = '{
        '{4'h9, 8'h08, 1'h1, 11'h100, 11'h000, 8'h40, 8'h01, 1'h0},
        '{4'h5, 8'h00, 1'h1, 11'h100, 11'h000, 8'hC0, 8'h02, 1'h1},
        '{4'h5, 8'h00, 1'h1, 11'h201, 11'h000, 8'hE0, 8'h04, 1'h1},
        '{4'h5, 8'h00, 1'h1, 11'h000, 11'h014, 8'hE0, 8'h03, 1'h1},
        '{4'h1, 8'h00, 1'h1, 11'h000, 11'h000, 8'h60, 8'h03, 1'h0},
        '{4'h5, 8'h00, 1'h0, 11'h000, 11'h000, 8'h00, 8'h00, 1'h0},
        '{4'h2, 8'h00, 1'h1, 11'h003, 11'h000, 8'h40, 8'h00, 1'h0},
        '{4'h5, 8'h00, 1'h1, 11'h000, 11'h003, 8'h10, 8'h00, 1'h0},
        '{4'h8, 8'h01, 1'h1, 11'h258, 11'h000, 8'h40, 8'h02, 1'h0}
    };
    logic        i_clk_sys = 1'h0, i_rst = 1'h1, jmp = 1'h1, sv = 1'h0;
    logic [15:0] sd = 16'h0000, od, p = 16'h0000, q = 16'h0000;
    logic [24:0] g, h;
    logic [7:0]  ird, iw;
    logic [3:0]  ia;
    logic        io_wr, io_rd, drd, ov, ow, oi;
    int          miscompares = 0, checked = 0, cyc = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    asfs_top #(.DEPTH_LOG2(10), .FRAG_LOG2(4)) i_asfs_top (.i_clk_sys, .i_rst, .i_superset_option_jumper(jmp),
        .i_sample_valid(sv), .i_sample_data(sd), .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_addr(ia), .i_io_wdata(iw),
        .i_data_rd(drd), .o_io_rdata(ird), .o_data(od), .o_data_valid(ov), .o_io_wait(ow), .o_irq(oi));
    asfs_host i_asfs_host (.i_clk_sys, .i_io_rdata(ird), .i_data(od), .i_data_valid(ov), .o_io_wr(io_wr),
        .o_io_rd(io_rd), .o_io_addr(ia), .o_io_wdata(iw), .o_data_rd(drd));
    task automatic chk(input logic [24:0] gv, input logic [24:0] ev);
        checked++;
        if (gv !== ev) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, gv, ev);
        end
    endtask
    task automatic test_done;
        if (cyc >= 5000)
            miscompares++;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc >= 5000)
            test_done();
    end
    initial begin
        asfs_row_t r;
        repeat (3) @(negedge i_clk_sys);
        i_rst = 1'h0;
        foreach (rows[k]) begin
            r = rows[k];
            jmp = r.j;
            i_asfs_host.xfer(3'h1, r.wa, r.wd, g);
            if (r.wa == ASFS_OFF_CHANNEL) q = p;
            repeat (r.n) begin
                {sv, sd, p} = {1'h1, p, p + 16'h0001};
                @(negedge i_clk_sys);
            end
            {sv, sd} = {1'h0, ~sd};
            repeat (r.m) begin
                i_asfs_host.xfer(3'h4, 4'h0, 8'h00, g);
                chk(25'(g[24:8]), 25'({1'h1, q}));
                q++;
            end
            repeat (4) @(negedge i_clk_sys);
            i_asfs_host.xfer(3'h2, ASFS_OFF_STATUS_HIGH, 8'h00, g);
            i_asfs_host.xfer(3'h2, ASFS_OFF_STATUS_LOW, 8'h00, h);
            chk(25'({g[7:0], h[7:0], oi}), 25'({r.hi, r.lo, r.irq}));
            $display("row %0d done", k);
        end
        i_rst = 1'h1;
        @(negedge i_clk_sys);
        i_rst = 1'h0;
        i_asfs_host.xfer(3'h4, 4'h0, 8'h00, g);
        chk(25'({g[24], ow, oi}), 25'h0);
        i_asfs_host.xfer(3'h2, ASFS_OFF_STATUS_HIGH, 8'h00, g);
        chk(25'(g[7:0]), 25'h10);
        $display("reset test done");
        test_done();
    end
endmodule
